// >>> hdl/irq_dispatch_pkg.sv
package irq_dispatch_pkg;
	localparam int unsigned NUM_SRC = 12;
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] ADDR_ENABLE = 12'h0A8;
	localparam logic [11:0] ADDR_PRIO = 12'h0AC;
	localparam logic [11:0] ADDR_EXT_EN = 12'h0B0;
	localparam logic [11:0] ADDR_STATUS = 12'h0B4;
	localparam logic [11:0] ADDR_MASK = 12'h0B8;
	localparam logic [11:0] ADDR_STATE = 12'h0BC;
	localparam logic [2:0] SEL_ENABLE = 3'h0;
	localparam logic [2:0] SEL_PRIO = 3'h1;
	localparam logic [2:0] SEL_EXT_EN = 3'h2;
	localparam logic [2:0] SEL_STATUS = 3'h3;
	localparam logic [2:0] SEL_MASK = 3'h4;
	localparam logic [2:0] SEL_STATE = 3'h5;
	localparam logic [2:0] SEL_NONE = 3'h7;
	localparam int unsigned EN_GLOBAL_BIT = 7;
	localparam int unsigned EN_GP_BIT = 6;
	localparam int unsigned EN_LOCAL_W = 6;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [11:0] PRIO_RESET = 12'h000;
	localparam logic [5:0] EXT_EN_RESET = 6'h00;
	localparam int unsigned STATUS_W = 2;
	localparam int unsigned ST_VECTORED = 0;
	localparam int unsigned ST_RETURNED = 1;
	localparam logic [1:0] STATUS_RESET = 2'h0;
	localparam logic [1:0] MASK_RESET = 2'h0;
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam int unsigned VEC_SHIFT = 3;
	localparam logic [3:0] LAST_INDEX = 4'hB;
	localparam int unsigned AUTO_CLEAR_W = 4;
	localparam int unsigned DETECT_CYCLES = 1;
	localparam int unsigned CALL_CYCLES = 4;
	localparam logic [1:0] CALL_LAST = 2'(CALL_CYCLES - 1);

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_DETECT = 2'h1,
		ST_CALL = 2'h3
	} disp_state_t;

	typedef struct packed {
		logic valid;
		logic high;
		logic [3:0] index;
	} grant_t;

	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} apb_req_t;
endpackage

// >>> hdl/irq_priority_pick.sv
module irq_priority_pick (
	input wire logic [11:0] req_i,
	input wire logic [11:0] high_i,
	output irq_dispatch_pkg::grant_t grant_o
);
	// Lowest set bit: {found, index}
	function automatic logic [4:0] first_set(input logic [11:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = irq_dispatch_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	logic [4:0] hi_pick;
	logic [4:0] any_pick;

	always_comb begin
		hi_pick = first_set(req_i & high_i);
		any_pick = first_set(req_i);
		if (hi_pick[4]) begin
			grant_o = '{valid: 1'b1, high: 1'b1, index: hi_pick[3:0]};
		end else begin
			grant_o = '{valid: any_pick[4], high: 1'b0, index: any_pick[3:0]};
		end
	end
endmodule

// >>> hdl/cpu_interrupt_dispatch.sv
// Functional notes
// [R1] Sample and decode requests every clock
// [R2] One detect cycle before the call
// [R3] Call lasts four cycles, five minimum
// [R4] One instruction runs after a return
// [R5] Worst case eighteen cycles with divide
// [R6] Equal or higher level in service defers
// [R7] Vectors 0x0003 step eight, reset 0x0000
// [R8] Auto-clear lines and timer overflow flags
// [R9] Lowest index wins within a level
// [R10] Enable register 0xA8, reset zero
// [R11] Global enable off blocks all sources
// [R12] High preempts low, never high
// [R13] Still pending after return re-enters
// [R14] Track level in service, pop on return
//
// Implementation choice: register access over APB.
module cpu_interrupt_dispatch (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [11:0] pending_i,
	input wire logic boundary_i,
	input wire logic return_from_interrupt_i,
	output logic call_o,
	output logic [15:0] vector_o,
	output logic [3:0] flag_clear_o,
	output logic [1:0] in_service_o,
	output logic irq_o
);
	irq_dispatch_pkg::apb_req_t bus;
	irq_dispatch_pkg::disp_state_t state_reg;
	irq_dispatch_pkg::grant_t pick;
	irq_dispatch_pkg::grant_t grant_reg;
	logic [7:0] enable_reg;
	logic [11:0] prio_reg;
	logic [5:0] ext_en_reg;
	logic [1:0] status_reg;
	logic [1:0] status_next;
	logic [1:0] mask_reg;
	logic [1:0] events;
	logic [31:0] prdata_reg;
	logic data_ok_reg;
	logic [2:0] sel;
	logic wr_en;
	logic [11:0] src_enable;
	logic [11:0] live_req;
	logic eligible;
	logic allow;
	logic [1:0] call_cnt_reg;
	logic [15:0] vector_reg;
	logic [3:0] clear_reg;
	logic active_hi_reg;
	logic active_lo_reg;
	logic enter_call;

	function automatic logic [2:0] decode(input logic [11:0] a);
		logic [2:0] s;
		s = irq_dispatch_pkg::SEL_NONE;
		unique case (a)
			irq_dispatch_pkg::ADDR_ENABLE: s = irq_dispatch_pkg::SEL_ENABLE;
			irq_dispatch_pkg::ADDR_PRIO: s = irq_dispatch_pkg::SEL_PRIO;
			irq_dispatch_pkg::ADDR_EXT_EN: s = irq_dispatch_pkg::SEL_EXT_EN;
			irq_dispatch_pkg::ADDR_STATUS: s = irq_dispatch_pkg::SEL_STATUS;
			irq_dispatch_pkg::ADDR_MASK: s = irq_dispatch_pkg::SEL_MASK;
			irq_dispatch_pkg::ADDR_STATE: s = irq_dispatch_pkg::SEL_STATE;
			default: s = irq_dispatch_pkg::SEL_NONE;
		endcase
		return s;
	endfunction

	function automatic logic [15:0] vec_of(input logic [3:0] idx);
		return irq_dispatch_pkg::VEC_BASE + {9'h000, idx, 3'h0};
	endfunction

	// Bus slave, no wait state: read data are registered during the setup cycle
	assign bus = '{sel: psel_i, enable: penable_i, write: pwrite_i, addr: paddr_i, wdata: pwdata_i};
	assign sel = decode(bus.addr);
	assign pready_o = bus.sel && bus.enable && ce_i && data_ok_reg;
	assign pslverr_o = pready_o && (sel == irq_dispatch_pkg::SEL_NONE);
	assign wr_en = pready_o && bus.write && (sel != irq_dispatch_pkg::SEL_NONE);
	assign prdata_o = prdata_reg;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			data_ok_reg <= 1'b0;
		end else if (ce_i) begin
			data_ok_reg <= bus.sel && !pready_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			prdata_reg <= 32'h0000_0000;
		end else if (ce_i && bus.sel) begin
			unique case (sel)
				irq_dispatch_pkg::SEL_ENABLE: prdata_reg <= {24'h00_0000, enable_reg};
				irq_dispatch_pkg::SEL_PRIO: prdata_reg <= {20'h0_0000, prio_reg};
				irq_dispatch_pkg::SEL_EXT_EN: prdata_reg <= {26'h000_0000, ext_en_reg};
				irq_dispatch_pkg::SEL_STATUS: prdata_reg <= {30'h0000_0000, status_reg};
				irq_dispatch_pkg::SEL_MASK: prdata_reg <= {30'h0000_0000, mask_reg};
				irq_dispatch_pkg::SEL_STATE: prdata_reg <= {16'h0000, grant_reg, state_reg,
					active_hi_reg, active_lo_reg, 4'h0, call_cnt_reg};
				default: prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			enable_reg <= irq_dispatch_pkg::ENABLE_RESET; // [R10]
		end else if (ce_i && wr_en && sel == irq_dispatch_pkg::SEL_ENABLE) begin
			enable_reg <= bus.wdata[7:0]; // [R10]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			prio_reg <= irq_dispatch_pkg::PRIO_RESET;
			ext_en_reg <= irq_dispatch_pkg::EXT_EN_RESET;
			mask_reg <= irq_dispatch_pkg::MASK_RESET;
		end else if (ce_i && wr_en) begin
			if (sel == irq_dispatch_pkg::SEL_PRIO) begin
				prio_reg <= bus.wdata[11:0];
			end
			if (sel == irq_dispatch_pkg::SEL_EXT_EN) begin
				ext_en_reg <= bus.wdata[5:0];
			end
			if (sel == irq_dispatch_pkg::SEL_MASK) begin
				mask_reg <= bus.wdata[1:0];
			end
		end
	end

	// Sticky events, write one to clear, a new event wins
	assign events[irq_dispatch_pkg::ST_VECTORED] = enter_call;
	assign events[irq_dispatch_pkg::ST_RETURNED] = return_from_interrupt_i;

	always_comb begin
		status_next = status_reg;
		if (wr_en && sel == irq_dispatch_pkg::SEL_STATUS) begin
			status_next = status_reg & ~bus.wdata[1:0];
		end
		status_next = status_next | events;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			status_reg <= irq_dispatch_pkg::STATUS_RESET;
		end else if (ce_i) begin
			status_reg <= status_next;
		end
	end

	assign irq_o = |(status_reg & mask_reg);

	// Request qualification
	assign src_enable = {ext_en_reg, enable_reg[irq_dispatch_pkg::EN_LOCAL_W-1:0]};
	assign live_req = pending_i & src_enable & {12{enable_reg[irq_dispatch_pkg::EN_GLOBAL_BIT]}}; // [R11]

	irq_priority_pick u_pick (
		.req_i(live_req),
		.high_i(prio_reg),
		.grant_o(pick)
	);

	// High only when no high in service; low only when nothing in service
	assign eligible = pick.valid && !active_hi_reg && (pick.high || !active_lo_reg); // [R6] [R12]
	// A return boundary never vectors: one more instruction runs first
	assign allow = boundary_i && !return_from_interrupt_i; // [R4] [R13]
	assign enter_call = (state_reg == irq_dispatch_pkg::ST_DETECT);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_reg <= irq_dispatch_pkg::ST_IDLE;
			call_cnt_reg <= 2'h0;
		end else if (ce_i) begin
			unique case (state_reg)
				irq_dispatch_pkg::ST_IDLE: begin
					if (eligible && allow) begin
						state_reg <= irq_dispatch_pkg::ST_DETECT; // [R1]
					end
				end
				irq_dispatch_pkg::ST_DETECT: begin
					state_reg <= irq_dispatch_pkg::ST_CALL; // [R2]
					call_cnt_reg <= 2'h0;
				end
				irq_dispatch_pkg::ST_CALL: begin
					if (call_cnt_reg == irq_dispatch_pkg::CALL_LAST) begin
						state_reg <= irq_dispatch_pkg::ST_IDLE; // [R3] [R5]
					end else begin
						call_cnt_reg <= call_cnt_reg + 2'h1;
					end
				end
				default: state_reg <= irq_dispatch_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			grant_reg <= '0;
		end else if (ce_i && state_reg == irq_dispatch_pkg::ST_IDLE) begin
			grant_reg <= pick; // [R9]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			vector_reg <= irq_dispatch_pkg::VEC_RESET; // [R7]
		end else if (ce_i && enter_call) begin
			vector_reg <= vec_of(grant_reg.index); // [R7]
		end
	end

	assign call_o = (state_reg == irq_dispatch_pkg::ST_CALL);
	assign vector_o = vector_reg;

	// External lines and timer 0/1 overflow flags are cleared on vectoring
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			clear_reg <= 4'h0;
		end else if (ce_i) begin
			if (enter_call && grant_reg.index < 4'(irq_dispatch_pkg::AUTO_CLEAR_W)) begin
				clear_reg <= 4'h1 << grant_reg.index[1:0]; // [R8]
			end else begin
				clear_reg <= 4'h0;
			end
		end
	end

	assign flag_clear_o = clear_reg;

	// Level in service: push on vectoring, pop the top level on a return outside the detect cycle
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			active_hi_reg <= 1'b0;
			active_lo_reg <= 1'b0;
		end else if (ce_i) begin
			if (enter_call) begin
				if (grant_reg.high) begin
					active_hi_reg <= 1'b1; // [R14]
				end else begin
					active_lo_reg <= 1'b1; // [R14]
				end
			end else if (return_from_interrupt_i) begin
				if (active_hi_reg) begin
					active_hi_reg <= 1'b0; // [R14]
				end else begin
					active_lo_reg <= 1'b0; // [R14]
				end
			end
		end
	end

	assign in_service_o = {active_hi_reg, active_lo_reg};

	// Checks
	a_detect_one_cycle: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R2]
		state_reg == irq_dispatch_pkg::ST_DETECT |=> call_o && !$past(call_o))
		else $error("detect did not last exactly one cycle");

	a_call_four_cycles: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R3]
		$rose(call_o) |-> call_o [*4] ##1 !call_o)
		else $error("call did not last four cycles");

	a_fast_response: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R1]
		(state_reg == irq_dispatch_pkg::ST_IDLE && eligible && allow)
		|=> state_reg == irq_dispatch_pkg::ST_DETECT ##1 call_o [*4] ##1 !call_o)
		else $error("response to a ready request not five cycles");

	a_response_bound: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R5]
		(state_reg == irq_dispatch_pkg::ST_IDLE && pick.valid && boundary_i && return_from_interrupt_i)
		##1 (boundary_i && !return_from_interrupt_i && eligible) |=> state_reg == irq_dispatch_pkg::ST_DETECT)
		else $error("request not taken after instruction following return");

	a_return_from_interrupt_one_more: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R4]
		(return_from_interrupt_i && state_reg == irq_dispatch_pkg::ST_IDLE) |=> state_reg != irq_dispatch_pkg::ST_DETECT)
		else $error("vectored at the return boundary");

	a_reenter_pending: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R13]
		(return_from_interrupt_i && !active_hi_reg && state_reg == irq_dispatch_pkg::ST_IDLE && pick.valid)
		##1 (allow && pick.valid && !active_hi_reg && !active_lo_reg
		&& state_reg == irq_dispatch_pkg::ST_IDLE)
		|=> state_reg == irq_dispatch_pkg::ST_DETECT)
		else $error("still pending request not re-entered");

	a_global_gate: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R11]
		(state_reg == irq_dispatch_pkg::ST_IDLE && !enable_reg[irq_dispatch_pkg::EN_GLOBAL_BIT])
		|=> state_reg == irq_dispatch_pkg::ST_IDLE)
		else $error("vectored with global enable off");

	a_high_not_preempted: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R12]
		(state_reg == irq_dispatch_pkg::ST_IDLE && active_hi_reg) |=> state_reg == irq_dispatch_pkg::ST_IDLE)
		else $error("high level routine preempted");

	a_equal_level_defer: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R6]
		(state_reg == irq_dispatch_pkg::ST_IDLE && active_lo_reg && !pick.high)
		|=> state_reg == irq_dispatch_pkg::ST_IDLE)
		else $error("equal level request not deferred");

	a_vector_map: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R7]
		call_o |-> vector_o == vec_of(grant_reg.index) && grant_reg.index <= irq_dispatch_pkg::LAST_INDEX)
		else $error("vector does not match granted source");

	a_auto_clear: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R8]
		$rose(call_o) |-> (flag_clear_o == ((grant_reg.index < 4'h4) ? (4'h1 << grant_reg.index[1:0]) : 4'h0))
		##1 flag_clear_o == 4'h0)
		else $error("pending flag clear pulse wrong");

	a_lowest_index: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R9]
		pick.valid |-> ((live_req & (pick.high ? prio_reg : ~prio_reg)
		& ((12'h001 << pick.index) - 12'h001)) == 12'h000))
		else $error("lower index of same level not granted");

	a_level_push: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R14]
		enter_call |=> (grant_reg.high ? active_hi_reg : active_lo_reg))
		else $error("level in service not recorded");

	a_enable_reset: assert property (@(posedge clk_i) // [R10]
		!rst_b_i |=> enable_reg == irq_dispatch_pkg::ENABLE_RESET)
		else $error("enable register not cleared by reset");

	a_global_masks: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R11]
		!enable_reg[irq_dispatch_pkg::EN_GLOBAL_BIT] |-> live_req == 12'h000)
		else $error("request live with global enable off");

	a_sample_every_cycle: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R1]
		state_reg == irq_dispatch_pkg::ST_IDLE |=> grant_reg == $past(pick))
		else $error("idle grant not sampled each cycle");

	a_return_pops: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R14]
		(return_from_interrupt_i && !enter_call) |=> in_service_o == ($past(active_hi_reg) ? {1'b0, $past(active_lo_reg)} : 2'b00))
		else $error("return did not pop the top level");

	a_clear_first_call: assert property (@(posedge clk_i iff ce_i) disable iff (!rst_b_i) // [R8]
		flag_clear_o != 4'h0 |-> call_o && !$past(call_o))
		else $error("flag clear outside first call cycle");
endmodule

// >>> testbench/src_seq_model.sv
module src_seq_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [11:0] set_i,
	input wire logic [11:0] clr_i,
	input wire logic stall_i,
	input wire logic return_from_interrupt_req_i,
	input wire logic call_i,
	input wire logic [3:0] flag_clear_i,
	output logic [11:0] pending_o,
	output logic boundary_o,
	output logic return_from_interrupt_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pending flags: set by sources, cleared by software or on vectoring
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pending_o <= 12'h000;
		end else begin
			pending_o <= (pending_o | set_i) & ~clr_i & ~{8'h00, flag_clear_i};
		end
	end
	// Instruction ends each cycle unless the call runs or a long instruction stalls
	assign boundary_o = !call_i && !stall_i;
	assign return_from_interrupt_o = return_from_interrupt_req_i && boundary_o;
endmodule

// >>> testbench/test_cpu_interrupt_dispatch.sv
module test_cpu_interrupt_dispatch;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, ce, psel, penable, pwrite, stall, return_from_interrupt_req;
	logic prev_call = 1'b0;
	logic pready, pslverr, boundary, return_from_interrupt, call, irq;
	logic [11:0] paddr, pend, set_v, clr_v;
	logic [31:0] pwdata, prdata, lfsr;
	logic [15:0] vec;
	logic [3:0] fclr;
	logic [1:0] insvc;
	logic [31:0] exp_rd[$];
	logic [19:0] exp_vec[$];
	int n_fail = 0;
	int n_checks = 0;
	int n;

	cpu_interrupt_dispatch uut (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .pending_i(pend), .boundary_i(boundary), .return_from_interrupt_i(return_from_interrupt), .call_o(call),
		.vector_o(vec), .flag_clear_o(fclr), .in_service_o(insvc), .irq_o(irq));
	src_seq_model far (.clk_i(clk), .rst_b_i(rst_b), .set_i(set_v), .clr_i(clr_v), .stall_i(stall),
		.return_from_interrupt_req_i(return_from_interrupt_req), .call_i(call), .flag_clear_i(fclr), .pending_o(pend), .boundary_o(boundary),
		.return_from_interrupt_o(return_from_interrupt));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		chk({pready, pslverr}, {1'b1, a < 12'h0A8 || a > 12'h0BC});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// Expected read data goes to the queue; the watcher compares it
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic pulse(input logic [11:0] s, input logic [11:0] c);
		@(posedge clk);
		set_v <= s;
		clr_v <= c;
		@(posedge clk);
		set_v <= 12'h000;
		clr_v <= 12'h000;
	endtask

	task automatic wait_call();
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (call !== 1'b1 && n < 40);
	endtask

	task automatic finish_call();
		repeat (3) begin
			@(posedge clk);
			chk(call, 1'b1);
		end
		@(posedge clk);
		chk(call, 1'b0);
	endtask

	task automatic quiet();
		repeat (20) begin
			@(posedge clk);
			chk(call, 1'b0);
		end
	endtask

	// Return, then s extra cycles of a long instruction
	task automatic do_return_from_interrupt(input int s);
		@(posedge clk);
		return_from_interrupt_req <= 1'b1;
		@(posedge clk);
		return_from_interrupt_req <= 1'b0;
		if (s > 0) begin
			stall <= 1'b1;
			repeat (s) @(posedge clk);
			stall <= 1'b0;
		end
	endtask

	// Watcher: compares read data and each new vectoring against the oldest note
	always @(posedge clk) begin
		prev_call <= call;
		if (psel && penable && pready && !pwrite) begin
			chk(prdata, exp_rd.pop_front());
		end
		if (call && !prev_call) begin
			chk({12'h000, vec, fclr}, {12'h000, exp_vec.pop_front()});
		end
	end

	initial begin
		#(100 * 5000);
		n_fail++;
		report_and_stop();
	end

	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		set_v = 12'h000;
		clr_v = 12'h000;
		stall = 1'b0;
		return_from_interrupt_req = 1'b0;
		lfsr = 32'h0000_429a;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		chk({vec, insvc, call, irq}, 20'h0_0000);
		rd(irq_dispatch_pkg::ADDR_ENABLE, 32'h0000_0000);
		rd(12'h0A0, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			wr(irq_dispatch_pkg::ADDR_ENABLE, lfsr);
			rd(irq_dispatch_pkg::ADDR_ENABLE, {24'h00_0000, lfsr[7:0]});
		end
		$display("register test done");
		wr(irq_dispatch_pkg::ADDR_ENABLE, 32'h0000_00bf);
		wr(irq_dispatch_pkg::ADDR_EXT_EN, 32'h0000_003f);
		wr(irq_dispatch_pkg::ADDR_MASK, 32'h0000_0001);
		for (int i = 0; i < 12; i++) begin
			// Only the four lowest sources clear themselves
			exp_vec.push_back({16'h0003 + 16'(8 * i), 4'(1 << i)});
			pulse(12'(1 << i), 12'h000);
			wait_call();
			chk(n, 3);
			finish_call();
			chk(pend[i], i >= 4);
			pulse(12'h000, 12'(1 << i));
			do_return_from_interrupt(0);
		end
		chk(irq, 1'b1);
		wr(irq_dispatch_pkg::ADDR_STATUS, 32'h0000_0003);
		rd(irq_dispatch_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(irq, 1'b0);
		wr(irq_dispatch_pkg::ADDR_MASK, 32'h0000_0000);
		$display("vector test done");
		exp_vec.push_back({16'h0013, 4'h4});
		exp_vec.push_back({16'h002b, 4'h0});
		pulse(12'h024, 12'h000);
		wait_call();
		chk(n, 3);
		finish_call();
		do_return_from_interrupt(0);
		wait_call();
		chk(n, 3);
		finish_call();
		pulse(12'h000, 12'h020);
		do_return_from_interrupt(0);
		chk(irq, 1'b0);
		wr(irq_dispatch_pkg::ADDR_MASK, 32'h0000_0001);
		rd(irq_dispatch_pkg::ADDR_MASK, 32'h0000_0001);
		chk(irq, 1'b1);
		$display("priority test done");
		repeat (3) exp_vec.push_back({16'h0023, 4'h0});
		pulse(12'h010, 12'h000);
		wait_call();
		chk(n, 3);
		finish_call();
		for (int s = 0; s < 8; s += 7) begin
			do_return_from_interrupt(s);
			wait_call();
			chk(n, 3);
			finish_call();
		end
		pulse(12'h000, 12'h010);
		chk(insvc, 2'b01);
		wr(irq_dispatch_pkg::ADDR_PRIO, 32'h0000_0005);
		exp_vec.push_back({16'h0003, 4'h1});
		pulse(12'h001, 12'h000);
		wait_call();
		chk(n, 3);
		finish_call();
		chk(insvc, 2'b11);
		pulse(12'h004, 12'h000);
		quiet();
		exp_vec.push_back({16'h0013, 4'h4});
		do_return_from_interrupt(0);
		wait_call();
		chk(n, 3);
		finish_call();
		do_return_from_interrupt(0);
		do_return_from_interrupt(0);
		@(posedge clk);
		chk(insvc, 2'b00);
		$display("latency test done");
		wr(irq_dispatch_pkg::ADDR_ENABLE, 32'h0000_003f);
		pulse(12'h020, 12'h000);
		quiet();
		exp_vec.push_back({16'h002b, 4'h0});
		wr(irq_dispatch_pkg::ADDR_ENABLE, 32'h0000_00bf);
		wait_call();
		chk(call, 1'b1);
		finish_call();
		pulse(12'h000, 12'h020);
		do_return_from_interrupt(0);
		$display("global enable test done");
		// Clock enable low freezes the running call
		exp_vec.push_back({16'h002b, 4'h0});
		pulse(12'h020, 12'h000);
		wait_call();
		chk(n, 3);
		ce <= 1'b0;
		repeat (5) begin
			@(posedge clk);
			chk(call, 1'b1);
		end
		ce <= 1'b1;
		finish_call();
		pulse(12'h000, 12'h020);
		do_return_from_interrupt(0);
		chk(32'(exp_vec.size()), 32'h0000_0000);
		$display("clock enable test done");
		report_and_stop();
	end
endmodule
